// file: spmc_pkg.sv
// Package of constants and types for the sleep and idle power-mode controller.
package spmc_pkg;

    // ************************************************************
    // Register indices; byte address is four times the index.
    // ************************************************************
    localparam logic [11:0] SPMC_IDX_REGULATOR = 12'h812;
    localparam logic [11:0] SPMC_IDX_RATE_IDLE = 12'h88C;
    localparam logic [11:0] SPMC_IDX_STATUS = 12'h900;
    localparam int SPMC_ADR_W = 14;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int SPMC_REG_LP_BIT = 1;
    localparam int SPMC_IDLE_BIT = 7;
    localparam int SPMC_REDUCED_RATE_ENABLE_BIT = 6;
    localparam int SPMC_ROI_BIT = 5;
    localparam int SPMC_DOE_BIT = 4;
    localparam int SPMC_RATIO_LSB = 0;
    localparam int SPMC_RATIO_W = 3;
    localparam int SPMC_ST_TO_BIT = 0;
    localparam int SPMC_ST_PD_BIT = 1;
    localparam int SPMC_ST_STATE_LSB = 2;

    // ************************************************************
    // Reset values and timing.
    // ************************************************************
    localparam logic SPMC_PD_RESET = 1'b1;
    localparam logic SPMC_TO_RESET = 1'b1;
    localparam int SPMC_OST_PERIODS = 1024;
    localparam int SPMC_CNT_W = 11;
    localparam int SPMC_DOZE_W = 8;
    localparam int SPMC_CLK_MHZ = 200;

    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_SLEEP = 3'h1,
        ST_OST = 3'h3,
        ST_REG = 3'h2,
        ST_NEXT = 3'h6,
        ST_NOP = 3'h7,
        ST_IDLE = 3'h5
    } spmc_state_t;

endpackage

// file: spmc_core.sv
// Sleep, idle and reduced-rate power-mode controller with a classic Wishbone register slave.
//
// Contract
// - Sleep instruction with idle select clear enters full Sleep.
// - Sleep entry clears watchdog; it keeps counting only if enabled in Sleep.
// - Sleep entry clears power-down flag and sets time-out flag.
// - Sleep stops CPU clock; internal, secondary and converter oscillators keep running.
// - I/O ports hold their drive state during Sleep; other resets unchanged.
// - Reset pin, brown-out and power-on reset fully reset; others wake and continue.
// - Sleep instruction prefetches the instruction at PC plus one.
// - Interrupt wakes only when its enable is set, regardless of global enable.
// - Global enable clear continues in line; set executes next then vectors.
// - Watchdog is cleared on every wake from Sleep.
// - Pending enabled interrupt with global enable clear makes Sleep a no-op.
// - Interrupt during or after Sleep wakes at once with watchdog cleared, flags updated.
// - Crystal modes wait 1024 oscillator periods on wake; others do not.
// - Regulator low-power bit puts regulator in low-power state during Sleep.
// - Waking from low-power Sleep adds a stabilization delay; normal mode does not.
// - Low-voltage variant has no low-power selection and no wake penalty.
// - Idle select set makes Sleep instruction enter Idle; CPU and memory halt.
// - System-clock peripherals run in Idle, stop in Sleep; internal-oscillator ones always run.
// - Enabled clock output keeps toggling during Idle.
// - Any interrupt ends Idle, idle select unchanged, so Sleep re-enters Idle.
// - Recover-on-interrupt with reduced rate active restores full speed on Idle exit.
// - Watchdog time-out in Idle wakes instead of resetting; reduced rate unchanged.
// - Regulator bit one selects low-power slower-wake Sleep; zero selects normal.
// - Recover-on-interrupt clears reduced-rate enable on service routine entry.
// - Ratio field 000 gives 1:2 up to 111 giving 1:256, doubling each step.
`timescale 1ns/10ps

module spmc_core
    import spmc_pkg::*;
#(
    parameter int REG_WAKE_NS = 200
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [SPMC_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sleep_exec_i,
    input wire logic irq_wake_pending_i,
    input wire logic global_interrupt_enable_i,
    input wire logic isr_entry_i,
    input wire logic isr_exit_i,
    input wire logic wdt_timeout_i,
    input wire logic wdt_runs_in_sleep_i,
    input wire logic osc_crystal_mode_i,
    input wire logic low_voltage_variant_i,
    input wire logic clock_output_enable_n_i,
    output logic cpu_clk_en_o,
    output logic cpu_cycle_en_o,
    output logic periph_sysclk_en_o,
    output logic internal_osc_mode_run_o,
    output logic io_hold_o,
    output logic wdt_clear_o,
    output logic wdt_run_o,
    output logic wdt_reset_o,
    output logic prefetch_next_o,
    output logic forced_nop_o,
    output logic vector_isr_o,
    output logic clkout_run_o,
    output logic regulator_low_power_o,
    output logic power_down_flag_o,
    output logic timeout_flag_o,
    output logic sleep_selects_idle_o,
    output logic reduced_rate_enable_o
);

    // ************************************************************
    // Timing derived from the clock rate.
    // ************************************************************
    // The regulator delay is rounded up to whole cycles and is never shorter than one,
    // so a small setting still leaves a cycle for the reference to settle.
    localparam int REG_WAKE_CYC_RAW = (REG_WAKE_NS * SPMC_CLK_MHZ + 999) / 1000;
    localparam int REG_WAKE_CYC = (REG_WAKE_CYC_RAW < 1) ? 1 : REG_WAKE_CYC_RAW;
    localparam logic [SPMC_CNT_W-1:0] OST_LAST = SPMC_CNT_W'(SPMC_OST_PERIODS - 1);
    localparam logic [SPMC_CNT_W-1:0] REG_LAST = SPMC_CNT_W'(REG_WAKE_CYC - 1);

    generate
        if (REG_WAKE_CYC > (1 << SPMC_CNT_W)) begin : g_bad_delay
            $error("Regulator wake delay does not fit the wake counter.");
        end
        if (REG_WAKE_NS < 0) begin : g_neg_delay
            $error("Regulator wake delay must not be negative.");
        end
        if (SPMC_OST_PERIODS > (1 << SPMC_CNT_W)) begin : g_bad_ost
            $error("Oscillator start-up wait does not fit the wake counter.");
        end
    endgenerate

    typedef struct packed {
        // Wake sequencing.
        spmc_state_t state;
        logic [SPMC_CNT_W-1:0] cnt;
        logic woke_irq;
        // Software-visible register bits.
        logic idle_sel;
        logic reduced_rate_enable;
        logic interrupt_restores_full_speed;
        logic reduced_rate_on_isr_exit;
        logic [SPMC_RATIO_W-1:0] ratio;
        logic vreg_lp;
        logic pd;
        logic to;
        // Bus slave.
        logic ack;
        logic [7:0] rdata;
        // Registered events; wdt_clear holds through the crystal wait.
        logic wdt_clear;
        logic prefetch;
        logic forced_nop;
        logic vector;
        // Reduced-rate divider.
        logic [SPMC_DOZE_W-1:0] doze_cnt;
        logic cyc_en;
    } spmc_regs_t;

    spmc_regs_t s;
    spmc_regs_t next_s;

    function automatic logic hit(input logic [SPMC_ADR_W-1:0] adr, input logic [11:0] idx);
        hit = (adr[SPMC_ADR_W-1:2] == idx);
    endfunction

    // Ratio code n means one CPU cycle in 2^(n+1) peripheral cycles.
    function automatic logic [SPMC_DOZE_W-1:0] ratio_mask(input logic [SPMC_RATIO_W-1:0] r);
        logic [SPMC_DOZE_W:0] span;
        span = (SPMC_DOZE_W+1)'(2) << r;
        ratio_mask = SPMC_DOZE_W'(span - (SPMC_DOZE_W+1)'(1));
    endfunction

    // ************************************************************
    // State decoding.
    // ************************************************************
    // The CPU executes in run and in the two cycles that finish a wake-up.
    function automatic logic cpu_running(input spmc_state_t st);
        cpu_running = (st == ST_RUN) || (st == ST_NEXT) || (st == ST_NOP);
    endfunction

    // The system clock is held off in Sleep and through both wake-up waits, so
    // nothing clocked from it can run before the oscillator and regulator settle.
    function automatic logic sysclk_stopped(input spmc_state_t st);
        sysclk_stopped = (st == ST_SLEEP) || (st == ST_OST) || (st == ST_REG);
    endfunction

    // Only a settled Sleep holds the pins; the wake-up waits already release them.
    function automatic logic asleep(input spmc_state_t st);
        asleep = (st == ST_SLEEP);
    endfunction

    logic lp_sleep;
    logic cpu_on;

    // The low-voltage variant is unregulated, so the selection bit is inert there.
    assign lp_sleep = s.vreg_lp & ~low_voltage_variant_i;

    assign cpu_on = cpu_running(s.state);

    // ************************************************************
    // Next-state logic.
    // ************************************************************
    always_comb begin
        logic acc;
        logic [7:0] rd;
        acc = 1'b0;
        rd = 8'h00;
        next_s = s;
        next_s.ack = 1'b0;
        next_s.wdt_clear = 1'b0;
        next_s.prefetch = 1'b0;
        next_s.forced_nop = 1'b0;
        next_s.vector = 1'b0;

        // Register slave: one wait state, unmapped reads return zero.
        // A new request is refused while ack stands, so a master that holds its strobe
        // one cycle too long is not answered twice.
        acc = wb_cyc_i & wb_stb_i & ~s.ack;
        if (hit(wb_adr_i, SPMC_IDX_REGULATOR)) begin
            rd[SPMC_REG_LP_BIT] = lp_sleep;
        end else if (hit(wb_adr_i, SPMC_IDX_RATE_IDLE)) begin
            rd[SPMC_IDLE_BIT] = s.idle_sel;
            rd[SPMC_REDUCED_RATE_ENABLE_BIT] = s.reduced_rate_enable;
            rd[SPMC_ROI_BIT] = s.interrupt_restores_full_speed;
            rd[SPMC_DOE_BIT] = s.reduced_rate_on_isr_exit;
            rd[SPMC_RATIO_LSB +: SPMC_RATIO_W] = s.ratio;
        end else if (hit(wb_adr_i, SPMC_IDX_STATUS)) begin
            rd[SPMC_ST_TO_BIT] = s.to;
            rd[SPMC_ST_PD_BIT] = s.pd;
            rd[SPMC_ST_STATE_LSB +: 3] = s.state;
        end
        if (acc) begin
            next_s.ack = 1'b1;
            next_s.rdata = rd;
            if (wb_we_i && wb_sel_i[0]) begin
                if (hit(wb_adr_i, SPMC_IDX_REGULATOR)) begin
                    next_s.vreg_lp = wb_dat_i[SPMC_REG_LP_BIT];
                end
                if (hit(wb_adr_i, SPMC_IDX_RATE_IDLE)) begin
                    next_s.idle_sel = wb_dat_i[SPMC_IDLE_BIT];
                    next_s.reduced_rate_enable = wb_dat_i[SPMC_REDUCED_RATE_ENABLE_BIT];
                    next_s.interrupt_restores_full_speed = wb_dat_i[SPMC_ROI_BIT];
                    next_s.reduced_rate_on_isr_exit = wb_dat_i[SPMC_DOE_BIT];
                    next_s.ratio = wb_dat_i[SPMC_RATIO_LSB +: SPMC_RATIO_W];
                end
            end
        end

        // Hardware updates come after the software write so that they win a tie.
        if (isr_entry_i) begin
            next_s.reduced_rate_on_isr_exit = s.reduced_rate_enable;
            if (s.interrupt_restores_full_speed) begin
                next_s.reduced_rate_enable = 1'b0;
            end
        end else if (isr_exit_i) begin
            next_s.reduced_rate_enable = s.reduced_rate_on_isr_exit;
        end

        // Reduced-rate divider; the CPU gets one cycle per ratio span.
        // The count restarts whenever reduced rate is switched on, so the first CPU cycle comes at once.
        if (s.reduced_rate_enable) begin
            next_s.doze_cnt = s.doze_cnt + SPMC_DOZE_W'(1);
        end else begin
            next_s.doze_cnt = '0;
        end
        next_s.cyc_en = ~s.reduced_rate_enable | ((s.doze_cnt & ratio_mask(s.ratio)) == '0);

        // Wake-up path. A wake event in Sleep first clears the watchdog, then waits
        // for the crystal to start and for the regulator to settle when either
        // applies. The next state runs the instruction fetched with the sleep
        // instruction; only a wake caused by an interrupt with the global enable set
        // then adds the forced no-op and the vector. Idle skips both waits because
        // the oscillators never stopped. A sleep instruction outside run is ignored,
        // as the CPU cannot issue one while it is halted.
        case (s.state)
            ST_RUN: begin
                // Idle leaves the flags and the watchdog as they are.
                if (sleep_exec_i) begin
                    if (irq_wake_pending_i && !global_interrupt_enable_i) begin
                        // Sleep acts as a no-op; watchdog and flags stay untouched.
                        next_s.state = ST_RUN;
                    end else begin
                        next_s.prefetch = 1'b1;
                        if (s.idle_sel) begin
                            next_s.state = ST_IDLE;
                        end else begin
                            next_s.state = ST_SLEEP;
                            next_s.wdt_clear = 1'b1;
                            next_s.pd = 1'b0;
                            next_s.to = 1'b1;
                        end
                    end
                end
            end
            ST_SLEEP: begin
                // The pending input already carries the per-source enable gating.
                if (irq_wake_pending_i || wdt_timeout_i) begin
                    next_s.wdt_clear = 1'b1;
                    next_s.woke_irq = irq_wake_pending_i;
                    next_s.cnt = '0;
                    if (osc_crystal_mode_i) begin
                        next_s.state = ST_OST;
                    end else if (lp_sleep) begin
                        next_s.state = ST_REG;
                    end else begin
                        next_s.state = ST_NEXT;
                    end
                end
            end
            ST_OST: begin
                // The watchdog stays clear while the oscillator starts.
                next_s.wdt_clear = 1'b1;
                next_s.cnt = s.cnt + SPMC_CNT_W'(1);
                if (s.cnt == OST_LAST) begin
                    next_s.cnt = '0;
                    next_s.state = lp_sleep ? ST_REG : ST_NEXT;
                end
            end
            ST_REG: begin
                // The low-power regulator settles; the watchdog may count again here.
                next_s.cnt = s.cnt + SPMC_CNT_W'(1);
                if (s.cnt == REG_LAST) begin
                    next_s.cnt = '0;
                    next_s.state = ST_NEXT;
                end
            end
            ST_IDLE: begin
                if (irq_wake_pending_i) begin
                    next_s.woke_irq = 1'b1;
                    if (s.interrupt_restores_full_speed && s.reduced_rate_enable) begin
                        next_s.reduced_rate_enable = 1'b0;
                    end
                    next_s.state = ST_NEXT;
                end else if (wdt_timeout_i) begin
                    // Not an interrupt: reduced rate is left as it is.
                    next_s.woke_irq = 1'b0;
                    next_s.state = ST_NEXT;
                end
            end
            ST_NEXT: begin
                // The prefetched instruction executes in this cycle.
                if (s.woke_irq && global_interrupt_enable_i) begin
                    next_s.forced_nop = 1'b1;
                    next_s.state = ST_NOP;
                end else begin
                    next_s.state = ST_RUN;
                end
            end
            ST_NOP: begin
                // The vector fetch follows the forced no-op.
                next_s.vector = 1'b1;
                next_s.state = ST_RUN;
            end
            default: begin
                next_s.state = ST_RUN;
            end
        endcase
    end

    // ************************************************************
    // State register.
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Reset pin, brown-out and power-on all arrive here as a full reset.
            // Pulses and ack start low, so nothing is acknowledged in the first cycle after reset.
            s <= '0;
            s.state <= ST_RUN;
            s.pd <= SPMC_PD_RESET;
            s.to <= SPMC_TO_RESET;
            s.cyc_en <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    // The level outputs are decoded from the state register; wdt_run_o, wdt_reset_o, clkout_run_o and regulator_low_power_o
    // also follow inputs at once. Registered pulses prefetch_next_o, forced_nop_o, vector_isr_o last one cycle; wdt_clear_o holds through the crystal wait.
    assign wb_dat_o = {24'h000000, s.rdata};
    assign wb_ack_o = s.ack;
    assign cpu_clk_en_o = cpu_on;
    assign cpu_cycle_en_o = s.cyc_en & cpu_on;
    assign periph_sysclk_en_o = ~sysclk_stopped(s.state);
    assign internal_osc_mode_run_o = 1'b1;
    assign io_hold_o = asleep(s.state);
    assign wdt_clear_o = s.wdt_clear;
    assign wdt_run_o = ~asleep(s.state) | wdt_runs_in_sleep_i;
    // Watchdog reset is blocked while asleep or idle; there it wakes instead.
    assign wdt_reset_o = wdt_timeout_i & cpu_on;
    assign prefetch_next_o = s.prefetch;
    assign forced_nop_o = s.forced_nop;
    assign vector_isr_o = s.vector;
    assign clkout_run_o = ~clock_output_enable_n_i & periph_sysclk_en_o;
    assign regulator_low_power_o = lp_sleep & asleep(s.state);
    assign power_down_flag_o = s.pd;
    assign timeout_flag_o = s.to;
    assign sleep_selects_idle_o = s.idle_sel;
    assign reduced_rate_enable_o = s.reduced_rate_enable;

endmodule

// file: spmc_irq_model.sv
// Behavioural model of the interrupt logic and CPU vector fetch facing the power-mode controller.
`timescale 1ns/10ps
module spmc_irq_model #(
    parameter int LAT = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic raise_i,
    input wire logic clear_i,
    input wire logic vector_i,
    output logic pending_o,
    output logic isr_entry_o
);
    int cnt;
    // A raise stands for a source whose enable and flag are both set; only then is a wake requested.
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 0;
            pending_o <= 1'b0;
            isr_entry_o <= 1'b0;
        end else begin
            isr_entry_o <= vector_i;
            if (raise_i) begin
                cnt <= LAT;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
            if (clear_i) begin
                pending_o <= 1'b0;
            end else if (cnt == 1) begin
                pending_o <= 1'b1;
            end
        end
    end
endmodule

// file: spmc_chk.sv
// Concurrent checks on the ports of the power-mode controller.
`timescale 1ns/10ps
module spmc_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sleep_exec_i,
    input wire logic irq_wake_pending_i,
    input wire logic global_interrupt_enable_i,
    input wire logic wdt_timeout_i,
    input wire logic low_voltage_variant_i,
    input wire logic clock_output_enable_n_i,
    input wire logic cpu_clk_en_o,
    input wire logic periph_sysclk_en_o,
    input wire logic internal_osc_mode_run_o,
    input wire logic io_hold_o,
    input wire logic wdt_clear_o,
    input wire logic wdt_reset_o,
    input wire logic prefetch_next_o,
    input wire logic forced_nop_o,
    input wire logic vector_isr_o,
    input wire logic clkout_run_o,
    input wire logic regulator_low_power_o,
    input wire logic power_down_flag_o,
    input wire logic timeout_flag_o,
    input wire logic sleep_selects_idle_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_sleep_entry: assert property (sleep_exec_i && cpu_clk_en_o && !sleep_selects_idle_o &&
        (global_interrupt_enable_i || !irq_wake_pending_i) |=> !cpu_clk_en_o && !power_down_flag_o
        && timeout_flag_o && wdt_clear_o && prefetch_next_o) else $error("sleep entry wrong");
    chk_sleep_noop: assert property (sleep_exec_i && cpu_clk_en_o && irq_wake_pending_i &&
        !global_interrupt_enable_i |=> cpu_clk_en_o && $stable(power_down_flag_o) && $stable(timeout_flag_o)
        && !wdt_clear_o) else $error("sleep not a no-op");
    chk_idle_entry: assert property (sleep_exec_i && cpu_clk_en_o && sleep_selects_idle_o &&
        !irq_wake_pending_i |=> !cpu_clk_en_o && periph_sysclk_en_o && !io_hold_o) else $error("idle entry wrong");
    chk_sleep_hold: assert property (io_hold_o |-> !cpu_clk_en_o && !periph_sysclk_en_o && internal_osc_mode_run_o)
        else $error("sleep clocks wrong");
    chk_wake_clear: assert property (io_hold_o && (irq_wake_pending_i || wdt_timeout_i) |=>
        wdt_clear_o && !io_hold_o) else $error("wake did not clear watchdog");
    chk_wdt_blocked: assert property (!cpu_clk_en_o && wdt_timeout_i |-> !wdt_reset_o)
        else $error("watchdog reset while halted");
    chk_vector_nop: assert property (vector_isr_o |-> $past(forced_nop_o) && $past(cpu_clk_en_o, 2))
        else $error("vector without forced nop");
    chk_lp_regulator: assert property (regulator_low_power_o |-> io_hold_o && !low_voltage_variant_i)
        else $error("regulator low power out of sleep");
    chk_clkout_idle: assert property (!cpu_clk_en_o && periph_sysclk_en_o && !clock_output_enable_n_i
        |-> clkout_run_o) else $error("clock output stopped in idle");
endmodule
bind spmc_core spmc_chk u_chk (.clk_i, .rst_i, .sleep_exec_i, .irq_wake_pending_i, .global_interrupt_enable_i,
    .wdt_timeout_i, .low_voltage_variant_i, .clock_output_enable_n_i, .cpu_clk_en_o, .periph_sysclk_en_o,
    .internal_osc_mode_run_o, .io_hold_o, .wdt_clear_o, .wdt_reset_o, .prefetch_next_o, .forced_nop_o, .vector_isr_o,
    .clkout_run_o, .regulator_low_power_o, .power_down_flag_o, .timeout_flag_o, .sleep_selects_idle_o);

// file: tb.sv
// Self-checking bench of the power-mode controller.
`timescale 1ns/10ps
module tb;
    import spmc_pkg::*;
    localparam logic [13:0] A_REG = {SPMC_IDX_REGULATOR, 2'h0};
    localparam logic [13:0] A_RATE = {SPMC_IDX_RATE_IDLE, 2'h0};
    localparam logic [13:0] A_ST = {SPMC_IDX_STATUS, 2'h0};
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [13:0] wb_adr_i = 14'h0000;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
    logic [3:0] wb_sel_i = 4'hF;
    logic sleep_exec_i = 1'b0, global_interrupt_enable_i = 1'b0, isr_exit_i = 1'b0, wdt_timeout_i = 1'b0;
    logic wdt_runs_in_sleep_i = 1'b0, osc_crystal_mode_i = 1'b0, low_voltage_variant_i = 1'b0;
    logic clock_output_enable_n_i = 1'b0, raise = 1'b0, clr = 1'b0;
    logic irq_wake_pending_i, isr_entry_i, wb_ack_o, cpu_clk_en_o, periph_sysclk_en_o, io_hold_o, wdt_run_o;
    logic wdt_clear_o, wdt_reset_o, prefetch_next_o, forced_nop_o, vector_isr_o, clkout_run_o, cpu_cycle_en_o;
    logic regulator_low_power_o, power_down_flag_o, timeout_flag_o, sleep_selects_idle_o, reduced_rate_enable_o;
    int num_errors = 0, checks_done = 0, cycles = 0, n;
    spmc_core #(.REG_WAKE_NS(5)) uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .sleep_exec_i, .irq_wake_pending_i, .global_interrupt_enable_i,
        .isr_entry_i, .isr_exit_i, .wdt_timeout_i, .wdt_runs_in_sleep_i, .osc_crystal_mode_i, .low_voltage_variant_i,
        .clock_output_enable_n_i, .cpu_clk_en_o, .cpu_cycle_en_o, .periph_sysclk_en_o, .internal_osc_mode_run_o(), .io_hold_o,
        .wdt_clear_o, .wdt_run_o, .wdt_reset_o, .prefetch_next_o, .forced_nop_o, .vector_isr_o, .clkout_run_o,
        .regulator_low_power_o, .power_down_flag_o, .timeout_flag_o, .sleep_selects_idle_o, .reduced_rate_enable_o);
    spmc_irq_model #(.LAT(3)) u_irq (.clk_i, .rst_i, .raise_i(raise), .clear_i(clr), .vector_i(vector_isr_o),
        .pending_o(irq_wake_pending_i), .isr_entry_o(isr_entry_i));
    always #2.5 clk_i = ~clk_i;
    task test_done;
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // The run is some 1200 cycles long, so a stuck wait ends well before this ceiling.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            test_done;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [13:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && k++ < 20);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task rd(input logic [13:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task tick;
        @(posedge clk_i);
        #1;
    endtask
    // Codes: 8 watchdog time-out, 4 raise interrupt, 2 clear interrupt, 1 sleep instruction.
    task drive(input logic [3:0] c);
        @(posedge clk_i) {wdt_timeout_i, raise, clr, sleep_exec_i} <= c;
        @(posedge clk_i) {wdt_timeout_i, raise, clr, sleep_exec_i} <= 4'h0;
        #1;
    endtask
    task wait_run;
        n = 0;
        while (cpu_clk_en_o !== 1'b1 && n < 3000) begin
            tick;
            n++;
        end
    endtask
    task t_regs;
        rd(A_ST, 32'h3);
        rd(A_REG, 32'h0);
        wb(1'b1, A_RATE, 32'hFF);
        rd(A_RATE, 32'hF7);
        wb(1'b1, A_RATE, 32'h0);
        wb(1'b1, A_REG, 32'hFF);
        rd(A_REG, 32'h2);
        wb(1'b1, A_REG, 32'h0);
        wb(1'b1, A_ST, 32'h0);
        rd(A_ST, 32'h3);
        rd(14'h0010, 32'h0);
        $display("test regs done");
    endtask
    task t_noop;
        drive(4'h4);
        repeat (4) tick;
        drive(4'h1);
        chk({cpu_clk_en_o, power_down_flag_o, timeout_flag_o, wdt_clear_o}, 4'hE);
        rd(A_ST, 32'h3);
        drive(4'h2);
        $display("test noop done");
    endtask
    task t_sleep_irq;
        @(posedge clk_i) global_interrupt_enable_i <= 1'b1;
        drive(4'h1);
        chk({cpu_clk_en_o, power_down_flag_o, timeout_flag_o, io_hold_o, prefetch_next_o, wdt_clear_o,
            periph_sysclk_en_o, wdt_run_o, regulator_low_power_o}, 9'h078);
        drive(4'h4);
        wait_run;
        chk(n < 8, 1'b1);
        chk({wdt_clear_o, forced_nop_o}, 2'h2);
        tick;
        chk(forced_nop_o, 1'b1);
        tick;
        chk(vector_isr_o, 1'b1);
        drive(4'h2);
        $display("test sleep irq done");
    endtask
    task t_wdt_wake;
        @(posedge clk_i) osc_crystal_mode_i <= 1'b1;
        wb(1'b1, A_REG, 32'h2);
        drive(4'h1);
        chk({regulator_low_power_o, io_hold_o}, 2'h3);
        drive(4'h8);
        chk(wdt_clear_o, 1'b1);
        wait_run;
        chk(n > 1022 && n < 1030, 1'b1);
        tick;
        chk(forced_nop_o, 1'b0);
        rd(A_ST, 32'h1);
        osc_crystal_mode_i <= 1'b0;
        wb(1'b1, A_REG, 32'h0);
        $display("test watchdog wake done");
    endtask
    task t_idle;
        @(posedge clk_i) global_interrupt_enable_i <= 1'b0;
        wb(1'b1, A_RATE, 32'hE0);
        drive(4'h1);
        chk({cpu_clk_en_o, periph_sysclk_en_o, clkout_run_o, io_hold_o}, 4'h6);
        @(posedge clk_i) wdt_timeout_i <= 1'b1;
        #1 chk(wdt_reset_o, 1'b0);
        drive(4'h0);
        wait_run;
        rd(A_RATE, 32'hE0);
        drive(4'h1);
        drive(4'h4);
        wait_run;
        rd(A_RATE, 32'hA0);
        drive(4'h2);
        wb(1'b1, A_RATE, 32'h0);
        $display("test idle done");
    endtask
    task t_doze;
        wb(1'b1, A_RATE, 32'h41);
        chk(reduced_rate_enable_o, 1'b1);
        n = 0;
        repeat (16) begin
            tick;
            n += cpu_cycle_en_o;
        end
        chk(n, 4);
        wb(1'b1, A_RATE, 32'h0);
        chk(reduced_rate_enable_o, 1'b0);
        $display("test doze done");
    endtask
    task t_lv;
        @(posedge clk_i) low_voltage_variant_i <= 1'b1;
        wb(1'b1, A_REG, 32'h2);
        rd(A_REG, 32'h0);
        drive(4'h1);
        chk(regulator_low_power_o, 1'b0);
        drive(4'h8);
        wait_run;
        low_voltage_variant_i <= 1'b0;
        wb(1'b1, A_REG, 32'h0);
        $display("test low voltage done");
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_noop;
        t_sleep_irq;
        t_wdt_wake;
        t_idle;
        t_doze;
        t_lv;
        test_done;
    end
endmodule
